// File: include/ps_config_params.svh
`ifndef PS_CONFIG_PARAMS_SVH
`define PS_CONFIG_PARAMS_SVH

// Power-on-reset delay held on the status line, in microseconds.
`define POR_DELAY_US        100
// Internal-oscillator initialization window, in microseconds.
`define INIT_MIN_US         175
`define INIT_MAX_US         437
// Core clock rate in MHz.
`define MCLK_MHZ            200
// User-clock enable delay in maximum serial-clock periods.
`define USER_CLK_EN_PERIODS 4
// Maximum serial-clock period in nanoseconds.
`define SCLK_MAX_PERIOD_NS  125
// User-clock periods of initialization after the enable delay.
`define USER_INIT_CYCLES    8576
// Default bitstream length in bits.
`define BITSTREAM_BITS      4096
// Option-bit positions inside the bitstream.
`define OPT_INIT_DONE_BIT   0
`define OPT_USER_CLK_BIT    1
`define OPT_DATA_IO_BIT     2
// Length of the option header in bits.
`define OPT_BITS            3
// Falling serial-clock edges needed after done.
`define DONE_FALL_EDGES     2

`endif

// File: include/ps_config_pkg.sv
package ps_config_pkg;

  typedef enum logic [2:0] {
    ST_POR,
    ST_WAIT_REQ,
    ST_LOAD,
    ST_DONE_EDGES,
    ST_INIT,
    ST_USER
  } cfg_state_e;

  typedef struct packed {
    logic initDoneEn;
    logic userClkSel;
    logic dataAsIo;
  } cfg_opts_s;

  typedef struct packed {
    logic requestN;
    logic sclk;
    logic sdata;
  } host_pins_s;

endpackage : ps_config_pkg

// File: rtl/passive_serial_config_load.sv
`timescale 1ns/1ps
`include "ps_config_params.svh"

// Contract
// [RQ1] In user mode all three control lines sit high and a low config request restarts loading.
// [RQ2] After power-up the status output is held low for the whole power-on-reset delay.
// [RQ3] Config done stays low after power-up, while waiting and while data is loading.
// [RQ4] The host must deliver the whole bitstream over the serial clock and data lines.
// [RQ5] Config done goes high only after every bit has been received without error.
// [RQ6] After config done the host gives two more falling serial-clock edges to start init.
// [RQ7] After configuration the host keeps driving the serial clock at a steady level.
// [RQ8] After configuration the serial data pin becomes user I/O per the loaded pin option.
// [RQ9] If the init-done option is loaded, the init-done output goes low at once.
// [RQ10] With the internal oscillator, user mode starts 175 to 437 us after config done.
// [RQ11] The user init clock is enabled no earlier than four max serial-clock periods after done.
// [RQ12] With the user clock, user mode starts no earlier than that delay plus 8576 user clocks.
// [RQ13] The host changes data between edges and a bit is captured on each rising clock edge.
module passive_serial_config_load
  import ps_config_pkg::*;
#(
  parameter int BITSTREAM_BITS = `BITSTREAM_BITS,
  parameter int POR_CYCLES     = `POR_DELAY_US * `MCLK_MHZ,
  parameter int INIT_CYCLES    = (`INIT_MIN_US + `INIT_MAX_US) / 2 * `MCLK_MHZ,
  parameter int USER_INIT      = `USER_INIT_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Host pins
  input  wire host_pins_s  hostPins,
  input  wire logic        userInitClock,
  // Status pins
  output logic             configStatusN,
  output logic             configDone,
  output logic             initDoneN,
  output logic             initDoneOe,
  // User mode, data-pin I/O, user-clock enable and parity error
  output logic             userMode,
  output logic             dataPinIsIo,
  output logic             userClkEnabled,
  output logic             crcError
);

  localparam int CLK_EN_CYCLES =
    (`USER_CLK_EN_PERIODS * `SCLK_MAX_PERIOD_NS * `MCLK_MHZ + 999) / 1000;
  localparam int CW = 32;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  host_pins_s meta_q;
  host_pins_s sync_q;
  host_pins_s prev_q;
  logic [1:0] ucSync_q;
  logic       ucPrev_q;

  always_ff @(posedge mclk) begin
    meta_q   <= hostPins;
    sync_q   <= meta_q;
    prev_q   <= sync_q;
    ucSync_q <= {ucSync_q[0], userInitClock};
    ucPrev_q <= ucSync_q[1];
  end

  // Edges are seen about three core cycles after the pin moves, so the host's phases must be longer.
  logic sclkRise;
  logic sclkFall;
  logic ucRise;
  assign sclkRise = sync_q.sclk & ~prev_q.sclk;
  assign sclkFall = ~sync_q.sclk & prev_q.sclk;
  assign ucRise   = ucSync_q[1] & ~ucPrev_q;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  cfg_state_e state_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] ucCnt_q;
  logic [CW-1:0] bitCnt_q;
  cfg_opts_s     opts_q;
  logic          optInitSeen_q;
  logic          parity_q;

  logic reqLow;
  assign reqLow = ~sync_q.requestN;

  // A failed stream freezes capture, so no later edge can complete it by accident.
  logic lastBit;
  logic streamOdd;
  assign lastBit   = state_q == ST_LOAD && sclkRise && !crcError &&
                     bitCnt_q == CW'(BITSTREAM_BITS - 1);
  assign streamOdd = parity_q ^ sync_q.sdata;

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_POR;
      cnt_q   <= '0;
    end else if (reqLow && state_q != ST_POR) begin
      state_q <= ST_WAIT_REQ; // RQ1
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ST_POR: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CW'(POR_CYCLES - 1)) begin
            state_q <= ST_WAIT_REQ; // RQ2
          end
        end
        ST_WAIT_REQ: begin
          state_q <= ST_LOAD;
          cnt_q   <= '0;
        end
        ST_LOAD: begin
          if (lastBit && !streamOdd) begin
            state_q <= ST_DONE_EDGES; // RQ5
            cnt_q   <= '0;
          end
        end
        ST_DONE_EDGES: begin
          cnt_q <= cnt_q + 1'b1;
          // The first fall only closes the last data bit; the extra edges follow it.
          if (sclkFall && ucCnt_q == CW'(`DONE_FALL_EDGES)) begin
            state_q <= ST_INIT; // RQ6
          end
        end
        ST_INIT: begin
          cnt_q <= cnt_q + 1'b1;
          if (!opts_q.userClkSel && cnt_q >= CW'(INIT_CYCLES)) begin
            state_q <= ST_USER; // RQ10
          end else if (opts_q.userClkSel && userClkEnabled &&
                       ucCnt_q > CW'(USER_INIT)) begin
            // The first counted rise only opens a whole user-clock period.
            state_q <= ST_USER; // RQ12
          end
        end
        ST_USER: state_q <= ST_USER;
        default: state_q <= ST_POR;
      endcase
    end
  end

  // Shared counter for done-edge count and user-clock periods.
  always_ff @(posedge mclk) begin
    if (srst || state_q == ST_LOAD || state_q == ST_WAIT_REQ) begin
      ucCnt_q <= '0;
    end else if (state_q == ST_DONE_EDGES && sclkFall) begin
      ucCnt_q <= ucCnt_q + 1'b1;
    end else if (state_q == ST_INIT && state_q != ST_DONE_EDGES) begin
      if (ucCnt_q != '0 && !userClkEnabled) begin
        ucCnt_q <= '0;
      end else if (userClkEnabled && ucRise) begin
        ucCnt_q <= ucCnt_q + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Bitstream capture
  // ****************************************************************
  always_ff @(posedge mclk) begin
    // Options survive the load; only a new request or a reset forgets them.
    if (srst || state_q == ST_WAIT_REQ) begin
      bitCnt_q      <= '0;
      opts_q        <= '0;
      optInitSeen_q <= 1'b0;
      parity_q      <= 1'b0;
    end else if (state_q == ST_LOAD && sclkRise && !crcError) begin // RQ13
      bitCnt_q <= bitCnt_q + 1'b1;
      parity_q <= parity_q ^ sync_q.sdata;
      if (bitCnt_q == CW'(`OPT_INIT_DONE_BIT)) begin
        opts_q.initDoneEn <= sync_q.sdata;
        optInitSeen_q     <= 1'b1; // RQ9
      end
      if (bitCnt_q == CW'(`OPT_USER_CLK_BIT)) begin
        opts_q.userClkSel <= sync_q.sdata;
      end
      if (bitCnt_q == CW'(`OPT_DATA_IO_BIT)) begin
        opts_q.dataAsIo <= sync_q.sdata;
      end
    end
  end

  // Even parity over the whole stream stands in for the integrity check. A failed
  // stream keeps done low until the host asks for a new configuration.
  always_ff @(posedge mclk) begin
    if (srst || state_q == ST_WAIT_REQ) begin
      crcError <= 1'b0;
    end else if (lastBit) begin
      crcError <= streamOdd; // RQ5
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // A request pulls the user-mode outputs down in the same cycle as status and done.
  logic inUser;
  assign inUser = state_q == ST_USER && !reqLow;

  always_ff @(posedge mclk) begin
    if (srst) begin
      configStatusN  <= 1'b0;
      configDone     <= 1'b0;
      initDoneOe     <= 1'b0;
      initDoneN      <= 1'b1;
      userMode       <= 1'b0;
      dataPinIsIo    <= 1'b0;
      userClkEnabled <= 1'b0;
    end else begin
      configStatusN  <= (state_q != ST_POR) && !reqLow; // RQ2
      configDone     <= (state_q == ST_DONE_EDGES || state_q == ST_INIT ||
                         state_q == ST_USER) && !reqLow; // RQ3
      initDoneOe     <= opts_q.initDoneEn && optInitSeen_q &&
                        state_q != ST_WAIT_REQ; // RQ9
      // The init-done line is low through initialization and released in user mode.
      initDoneN      <= inUser; // RQ9
      userMode       <= inUser; // RQ1
      dataPinIsIo    <= inUser && opts_q.dataAsIo; // RQ8
      userClkEnabled <= state_q == ST_INIT && opts_q.userClkSel &&
                        cnt_q >= CW'(CLK_EN_CYCLES); // RQ11
    end
  end

endmodule : passive_serial_config_load

// File: verif/ps_host_model.sv
`timescale 1ns/1ps
module ps_host_model
  import ps_config_pkg::*;
(
  input  wire logic mclk,
  output host_pins_s pins
);
  initial pins = 3'h4;
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic request;
    pins.requestN = 1'b0;
    tick(10);
    pins.requestN = 1'b1;
  endtask : request
  // The clock is parked low and kept driven between frames.
  task automatic pulse;
    tick(12);
    pins.sclk = 1'b1;
    tick(13);
    pins.sclk = 1'b0;
  endtask : pulse
  task automatic send(input logic [15:0] bits);
    for (int i = 0; i < 16; i++) begin
      pins.sdata = bits[i];
      pulse();
    end
    pins.sdata = ~pins.sdata;
  endtask : send
  task automatic falls;
    repeat (2) pulse();
  endtask : falls
endmodule : ps_host_model

// File: verif/passive_serial_config_load_assertions.sv
`timescale 1ns/1ps
module passive_serial_config_load_assertions
  import ps_config_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire host_pins_s hostPins,
  input wire logic       configStatusN,
  input wire logic       configDone,
  input wire logic       initDoneN,
  input wire logic       initDoneOe,
  input wire logic       userMode,
  input wire logic       dataPinIsIo,
  input wire logic       userClkEnabled,
  input wire logic       crcError
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_por_hold: assert property ($fell(srst) |-> !configStatusN [*8])
    else $error("status left power-on early");
  chk_user_lines: assert property (userMode |-> configStatusN && configDone)
    else $error("user mode without high lines");
  chk_req_status: assert property (!hostPins.requestN [*4] |-> ##2 !configStatusN)
    else $error("request low but status high");
  chk_req_done: assert property (!hostPins.requestN [*6] |-> !configDone)
    else $error("done high during request");
  chk_done_stands: assert property (configDone && hostPins.requestN |=> configDone)
    else $error("done dropped");
  chk_init_gap: assert property ($rose(userMode) |-> $past(configDone, 8))
    else $error("user mode too soon after done");
  chk_io_user: assert property (dataPinIsIo |-> userMode)
    else $error("data pin io outside user mode");
  chk_clk_late: assert property ($rose(userClkEnabled) |-> $past(configDone, 95))
    else $error("user clock enabled too soon");
  chk_oe_low: assert property ($rose(initDoneOe) |-> !initDoneN)
    else $error("init done not low");
  chk_done_clean: assert property (configDone |-> !crcError)
    else $error("done high after a failed stream");
  cover property ($rose(configDone));
  cover property ($rose(crcError));
  cover property ($rose(userMode));
  cover property ($rose(userClkEnabled));
endmodule : passive_serial_config_load_assertions
bind passive_serial_config_load passive_serial_config_load_assertions chk_u (
  .mclk(mclk), .srst(srst), .hostPins(hostPins), .configStatusN(configStatusN),
  .configDone(configDone), .initDoneN(initDoneN), .initDoneOe(initDoneOe),
  .userMode(userMode), .dataPinIsIo(dataPinIsIo), .userClkEnabled(userClkEnabled),
  .crcError(crcError)
);

// File: verif/passive_serial_config_load_tb.sv
`timescale 1ns/1ps
`include "ps_config_params.svh"
module passive_serial_config_load_tb
  import ps_config_pkg::*;
;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       userClk = 1'b0;
  logic       statN, done, idn, idoe, umode, isio, uen, crc;
  host_pins_s pins;
  int         err_total = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  // Shortened counts handed to the design and the rule windows scaled to them.
  localparam int INIT_CYC = 100;
  localparam int USER_CYC = 16;
  localparam int UC_PER   = 8;
  localparam int OSC_MID  = (`INIT_MIN_US + `INIT_MAX_US) / 2;
  localparam int OSC_LO   = INIT_CYC * `INIT_MIN_US / OSC_MID;
  localparam int OSC_HI   = INIT_CYC * `INIT_MAX_US / OSC_MID;
  localparam int EN_GAP   = `USER_CLK_EN_PERIODS * `SCLK_MAX_PERIOD_NS * `MCLK_MHZ / 1000;
  localparam int USER_MIN = USER_CYC * UC_PER;
  localparam int USER_MAX = (USER_CYC + 2) * UC_PER;
  always #2.5 mclk = ~mclk;
  always @(negedge mclk) userClk <= (cyc % (UC_PER / 2) == 0) ? ~userClk : userClk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  passive_serial_config_load #(
    .BITSTREAM_BITS(16), .POR_CYCLES(50), .INIT_CYCLES(INIT_CYC), .USER_INIT(USER_CYC)
  ) dut_u (
    .mclk(mclk), .srst(srst), .hostPins(pins), .userInitClock(userClk),
    .configStatusN(statN), .configDone(done), .initDoneN(idn), .initDoneOe(idoe),
    .userMode(umode), .dataPinIsIo(isio), .userClkEnabled(uen), .crcError(crc)
  );
  ps_host_model host_u (.mclk(mclk), .pins(pins));
  // ****************
  // Scenarios
  // ****************
  task automatic chk(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic t_por;
    repeat (40) @(negedge mclk);
    chk("status", 1'b0, statN);
    chk("done", 1'b0, done);
    repeat (20) @(negedge mclk);
    chk("status", 1'b1, statN);
  endtask : t_por
  // Stream with the options in bits 0 to 2; bit 15 makes the parity even unless odd is set.
  function automatic logic [15:0] make_stream(input cfg_opts_s o, input logic odd);
    logic [15:0] s;
    s = {1'b0, 12'ha5c, o.dataAsIo, o.userClkSel, o.initDoneEn};
    s[15] = (^s) ^ odd;
    return s;
  endfunction : make_stream
  // A stream with bad parity must leave done low and flag the error.
  task automatic t_bad;
    host_u.request();
    host_u.send(make_stream(3'h0, 1'b1));
    repeat (20) @(negedge mclk);
    chk("bad done", 1'b0, done);
    chk("bad crc", 1'b1, crc);
  endtask : t_bad
  // Done-based gaps are counted in cycles from the first cycle that shows done high; the user gap is counted from the first cycle with the clock enabled.
  task automatic t_config(input cfg_opts_s o);
    int tDone = -1;
    int tEn = -1;
    int tUm = -1;
    host_u.request();
    fork
      host_u.send(make_stream(o, 1'b0));
      begin
        repeat (375) @(negedge mclk);
        chk("done early", 1'b0, done);
        for (int i = 0; i < 40 && tDone < 0; i++) begin
          @(negedge mclk);
          if (done) tDone = cyc;
        end
      end
    join
    chk("done", 1'b1, done);
    chk("crc", 1'b0, crc);
    chk("init oe", o.initDoneEn, idoe);
    chk("init low", 1'b0, idn);
    fork
      host_u.falls();
      for (int i = 0; i < 900 && tUm < 0; i++) begin
        @(negedge mclk);
        if (uen && tEn < 0) tEn = cyc;
        if (umode) tUm = cyc;
      end
    join
    chk("done seen", 1'b1, tDone >= 0);
    if (o.userClkSel) begin
      chk("clk en gap", 1'b1, tEn >= 0 && tEn - tDone >= EN_GAP);
      chk("user gap", 1'b1, tUm - tEn >= USER_MIN && tUm - tEn <= USER_MAX);
    end else begin
      chk("osc gap", 1'b1, tUm - tDone >= OSC_LO && tUm - tDone <= OSC_HI && tEn < 0);
    end
    chk("user lines", 1'b1, statN & done & umode);
    chk("data io", o.dataAsIo, isio);
  endtask : t_config
  initial begin
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    t_por();
    t_bad();
    t_config(3'h5);
    t_config(3'h2);
    end_of_test();
  end
endmodule : passive_serial_config_load_tb
